// file: rtl/program_page_core.sv
module program_page_core
  import program_page_pkg::*;
(
  input  wire logic        clk_sys_in,   // System clock
  input  wire logic        rst_in,       // Synchronous reset, active high
  program_page_if.core     map_if,       // Toward the mapper
  input  wire logic [3:0]  sw_addr_in,   // Register index
  input  wire logic [15:0] sw_wdata_in,  // Write data
  input  wire logic        sw_wr_in,     // Write strobe
  input  wire logic        sw_rd_in,     // Read strobe
  output logic [15:0]      sw_rdata_out  // Read data, cycle after sw_rd_in
);
  import program_page_pkg::*;

  logic                fetch_req_reg;
  logic [PC_W-1:0]     fetch_pc_reg;
  logic                call_reg;
  logic [PC_W-1:0]     call_addr_reg;
  logic                pop_reg;
  logic                s1_valid_reg;
  logic                s1_bit_reg;
  logic [DATA_W-1:0]   s1_addr_reg;
  logic [DATA_W-1:0]   s1_data_reg;
  logic                wr_reg;
  logic                bit_reg;
  logic [DATA_W-1:0]   addr_reg;
  logic [DATA_W-1:0]   data_reg;
  logic [PAGE_W-1:0]   image_reg;
  logic [1:0]          ctrl_reg;
  logic                refused_reg;
  logic                in_static_reg;
  logic                seen_reg;
  logic [DATA_W+1:0]   last_fetch_reg;
  logic [15:0]         rdata_reg;
  logic                dw_req;
  logic                page_req;
  logic                page_bad;

  assign dw_req   = sw_wr_in && (sw_addr_in == HREG_DWRITE || sw_addr_in == HREG_DBIT);
  assign page_req = dw_req && sw_addr_in == HREG_DWRITE && sw_wdata_in[15:8] == PAGE_SEL_ADDR;
  // Page change refused inside service unless the image scheme is enabled,
  // and from a dynamic page, where the next fetch would land on another page
  assign page_bad = page_req && ((ctrl_reg[CTRL_ISR_BIT] && !ctrl_reg[CTRL_ALLOW_BIT]) // [R10]
                                 || (seen_reg && !in_static_reg)); // [R9]

  // Fetch, call and return go out one cycle after the software write
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      fetch_req_reg <= 1'b0;
      fetch_pc_reg  <= '0;
      call_reg      <= 1'b0;
      call_addr_reg <= '0;
      pop_reg       <= 1'b0;
    end
    else
    begin
      fetch_req_reg <= sw_wr_in && sw_addr_in == HREG_FETCH; // [R6]
      call_reg      <= sw_wr_in && sw_addr_in == HREG_CALL;
      pop_reg       <= sw_wr_in && sw_addr_in == HREG_RET;
      if (sw_wr_in && sw_addr_in == HREG_FETCH)
        fetch_pc_reg <= sw_wdata_in[PC_W-1:0];
      if (sw_wr_in && sw_addr_in == HREG_CALL)
        call_addr_reg <= sw_wdata_in[PC_W-1:0];
    end
  end

  // Track where the last fetch ran so page moves can be checked
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      in_static_reg <= 1'b1;
      seen_reg      <= 1'b0;
    end
    else if (sw_wr_in && sw_addr_in == HREG_FETCH)
    begin
      in_static_reg <= sw_wdata_in[PC_W-1];
      seen_reg      <= 1'b1;
    end
  end

  // Data writes take two stages so the image lands a cycle before the strobe
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      s1_valid_reg <= 1'b0;
      s1_bit_reg   <= 1'b0;
      s1_addr_reg  <= '0;
      s1_data_reg  <= '0;
      wr_reg       <= 1'b0;
      bit_reg      <= 1'b0;
      addr_reg     <= '0;
      data_reg     <= '0;
    end
    else
    begin
      s1_valid_reg <= dw_req && !page_bad;
      if (dw_req)
      begin
        s1_bit_reg  <= (sw_addr_in == HREG_DBIT);
        s1_addr_reg <= sw_wdata_in[15:8];
        s1_data_reg <= sw_wdata_in[7:0];
      end
      wr_reg <= s1_valid_reg;
      if (s1_valid_reg)
      begin
        bit_reg  <= s1_bit_reg;
        addr_reg <= s1_addr_reg;
        data_reg <= s1_data_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      image_reg <= PAGE_RESET;
    else if (page_req && !page_bad)
      image_reg <= sw_wdata_in[PAGE_W-1:0]; // [R11]
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      ctrl_reg <= '0;
    else if (sw_wr_in && sw_addr_in == HREG_CTRL)
      ctrl_reg <= sw_wdata_in[1:0];
  end

  // Sticky refusal flag; a new refusal beats a same-cycle clear
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      refused_reg <= 1'b0;
    else if (page_bad)
      refused_reg <= 1'b1;
    else if (sw_wr_in && sw_addr_in == HREG_STATUS && sw_wdata_in[STAT_REFUSED])
      refused_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      last_fetch_reg <= '0;
    else if (map_if.fetch_valid)
      last_fetch_reg <= {map_if.fetch_class, map_if.fetch_data};
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      rdata_reg <= '0;
    else if (sw_rd_in)
    begin
      if (sw_addr_in == HREG_FETCH)
        rdata_reg <= {6'h00, last_fetch_reg};
      else if (sw_addr_in == HREG_RET)
        rdata_reg <= {4'h0, map_if.ret_addr};
      else if (sw_addr_in == HREG_CTRL)
        rdata_reg <= {14'h0000, ctrl_reg};
      else if (sw_addr_in == HREG_STATUS)
        rdata_reg <= {10'h000, seen_reg, in_static_reg, image_reg, map_if.stack_empty, refused_reg};
      else
        rdata_reg <= '0;
    end
    else
      rdata_reg <= '0;
  end

  assign map_if.fetch_req   = fetch_req_reg;
  assign map_if.fetch_pc    = fetch_pc_reg;
  assign map_if.call_push   = call_reg;
  assign map_if.call_addr   = call_addr_reg;
  assign map_if.ret_pop     = pop_reg;
  assign map_if.data_wr     = wr_reg;
  assign map_if.data_bit_op = bit_reg;
  assign map_if.data_addr   = addr_reg;
  assign map_if.data_wdata  = data_reg;
  assign sw_rdata_out       = rdata_reg;

endmodule

// file: rtl/program_page_if.sv
interface program_page_if;
  import program_page_pkg::*;

  logic                fetch_req;
  logic [PC_W-1:0]     fetch_pc;
  logic                fetch_valid;
  logic [DATA_W-1:0]   fetch_data;
  fetch_class_e        fetch_class;
  logic                data_wr;
  logic                data_bit_op;
  logic [DATA_W-1:0]   data_addr;
  logic [DATA_W-1:0]   data_wdata;
  logic                call_push;
  logic [PC_W-1:0]     call_addr;
  logic                ret_pop;
  logic [PC_W-1:0]     ret_addr;
  logic                stack_empty;

  modport mapper (
    input  fetch_req, fetch_pc, data_wr, data_bit_op, data_addr, data_wdata,
           call_push, call_addr, ret_pop,
    output fetch_valid, fetch_data, fetch_class, ret_addr, stack_empty
  );

  modport core (
    output fetch_req, fetch_pc, data_wr, data_bit_op, data_addr, data_wdata,
           call_push, call_addr, ret_pop,
    input  fetch_valid, fetch_data, fetch_class, ret_addr, stack_empty
  );

endinterface

// file: rtl/program_page_mapper.sv
// Chosen here: strobed register access.
module program_page_mapper
  import program_page_pkg::*;
(
  input  wire logic                          clk_sys_in,          // System clock
  input  wire logic                          rst_in,              // Synchronous reset, active high
  program_page_if.mapper                     core_if,             // Core fetch and data-write side
  output logic [program_page_pkg::MEM_AW-1:0] mem_addr_out,       // Program memory byte address
  output logic                               mem_rd_out,          // Program memory read enable
  input  wire logic [program_page_pkg::DATA_W-1:0] mem_data_in,   // Memory data, valid with mem_rd_out
  output logic [program_page_pkg::PAGE_W-1:0] page_out,           // Current page select value
  output logic                               page_written_out,    // Page select written since reset
  output logic [program_page_pkg::DEPTH_W-1:0] stack_depth_out,   // Return stack fill level
  output logic                               stack_overflow_out,  // Sticky: push onto full stack
  output logic                               stack_underflow_out  // Sticky: pop from empty stack
);
  import program_page_pkg::*;

  logic [PAGE_W-1:0]  page_reg;
  logic               page_written_reg;
  logic               page_wr;
  logic [MEM_AW-1:0]  mem_addr_reg;
  logic               mem_rd_reg;
  fetch_class_e       pend_class_reg;
  logic               fetch_valid_reg;
  logic [DATA_W-1:0]  fetch_data_reg;
  fetch_class_e       fetch_class_reg;
  logic [PC_W-1:0]    stack_reg [STACK_N];
  logic [DEPTH_W-1:0] depth_reg;
  logic [DEPTH_W-1:0] depth_next;
  logic [PC_W-1:0]    ret_addr_reg;
  logic               overflow_reg;
  logic               underflow_reg;
  logic               do_push;
  logic               do_pop;
  logic [PC_W-1:0]    pop_value;

  // Level tests shared by the depth, pop, flag and empty logic
  function automatic logic level_full(input logic [DEPTH_W-1:0] lvl);
    return lvl == DEPTH_FULL;
  endfunction

  function automatic logic level_none(input logic [DEPTH_W-1:0] lvl);
    return lvl == '0;
  endfunction

  // Page select write decode: whole-byte writes to its data address only.
  // Bit-set/clear cycles are ignored since the hardware cannot merge them.
  always_comb
  begin
    page_wr = 1'b0;
    if (core_if.data_wr && !core_if.data_bit_op && core_if.data_addr == PAGE_SEL_ADDR) // [R5]
      page_wr = 1'b1;
  end

  // Reset gives a fixed value only so simulation stays clean; software may not rely on it
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      page_reg <= PAGE_RESET; // [R14]
    else if (page_wr)
      page_reg <= core_if.data_wdata[PAGE_W-1:0]; // [R13]
  end

  // Only data writes touch the page; stack traffic never does
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      page_written_reg <= 1'b0;
    else if (page_wr)
      page_written_reg <= 1'b1; // [R7]
  end

  // Fetch stage 1: translate the counter into a physical address.
  // A page write landing in the same cycle only affects later fetches,
  // so software must let the write settle before jumping low.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      mem_addr_reg   <= '0;
      mem_rd_reg     <= 1'b0;
      pend_class_reg <= FETCH_CODE;
    end
    else
    begin
      mem_rd_reg <= core_if.fetch_req; // [R1]
      if (core_if.fetch_req)
      begin
        // Upper half forced to static page, lower half follows page select
        mem_addr_reg   <= phys_addr(core_if.fetch_pc, page_reg); // [R2] [R3] [R4] [R15]
        pend_class_reg <= classify(core_if.fetch_pc); // [R8]
      end
    end
  end

  // Fetch stage 2: capture memory data; memory answers in the read cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      fetch_valid_reg <= 1'b0;
      fetch_data_reg  <= '0;
      fetch_class_reg <= FETCH_CODE;
    end
    else
    begin
      fetch_valid_reg <= mem_rd_reg;
      if (mem_rd_reg)
      begin
        fetch_data_reg  <= mem_data_in;
        fetch_class_reg <= pend_class_reg;
      end
    end
  end

  // A simultaneous push and pop is illegal; push wins so no address is lost
  assign do_push = core_if.call_push;
  assign do_pop  = core_if.ret_pop && !core_if.call_push;

  // Depth saturates at six; the overflow flag records the lost entry
  always_comb
  begin
    depth_next = depth_reg;
    if (do_push && !level_full(depth_reg))
      depth_next = depth_reg + 3'h1;
    else if (do_pop && !level_none(depth_reg))
      depth_next = depth_reg - 3'h1;
  end

  // Pop on an empty stack returns zero rather than a stale entry
  always_comb
  begin
    pop_value = '0;
    if (!level_none(depth_reg))
      pop_value = stack_reg[0];
  end

  // Six-entry shift stack: entry 0 is the top; a push when full drops the oldest
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < STACK_N; i++)
        stack_reg[i] <= '0;
    end
    else if (do_push)
    begin
      stack_reg[0] <= core_if.call_addr; // [R12]
      for (int i = 1; i < STACK_N; i++)
        stack_reg[i] <= stack_reg[i-1];
    end
    else if (do_pop)
    begin
      for (int i = 0; i < STACK_N - 1; i++)
        stack_reg[i] <= stack_reg[i+1];
      stack_reg[STACK_N-1] <= '0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      depth_reg <= '0;
    else
      depth_reg <= depth_next; // [R12]
  end

  // Popped address holds until the next pop, so software may read it late
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      ret_addr_reg <= '0;
    else if (do_pop)
      ret_addr_reg <= pop_value; // [R12]
  end

  // Sticky misuse flags, cleared only by reset so software can poll them late
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      overflow_reg <= 1'b0;
    else if (do_push && level_full(depth_reg))
      overflow_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      underflow_reg <= 1'b0;
    else if (do_pop && level_none(depth_reg))
      underflow_reg <= 1'b1;
  end

  // Every output below is a register or a plain decode of one
  assign core_if.fetch_valid = fetch_valid_reg;
  assign core_if.fetch_data  = fetch_data_reg;
  assign core_if.fetch_class = fetch_class_reg;
  assign core_if.ret_addr    = ret_addr_reg;
  assign core_if.stack_empty = level_none(depth_reg);

  assign mem_addr_out        = mem_addr_reg;
  assign mem_rd_out          = mem_rd_reg;
  assign page_out            = page_reg;
  assign page_written_out    = page_written_reg;
  assign stack_depth_out     = depth_reg;
  assign stack_overflow_out  = overflow_reg;
  assign stack_underflow_out = underflow_reg;

endmodule

// file: rtl/program_page_pkg.sv
// Function
// [R1] 12-bit fetch counter, four 2-Kbyte pages
// [R2] Counter bit 11 set always hits static page
// [R3] Counter bit 11 clear hits selected page
// [R4] Static page also reachable when selected below
// [R5] Page select at CAh, write-only, no bit-ops
// [R6] Software writes page before lower-range fetches
// [R7] Calls, returns, interrupts leave page untouched
// [R8] Static page holds interrupt, NMI, reset vectors
// [R9] Dynamic-to-dynamic moves pass through static page
// [R10] No page change inside interrupt service
// [R11] RAM image of page updated before write
// [R12] Six-level return stack for calls, interrupts
// [R13] Two low bits select page; rest unused
// [R14] Page select undefined after reset
// [R15] Memory address is page joined with PC[10:0]
package program_page_pkg;

  localparam int PC_W    = 12;
  localparam int MEM_AW  = 13;
  localparam int PAGE_W  = 2;
  localparam int DATA_W  = 8;
  localparam int STACK_N = 6;
  localparam int DEPTH_W = 3;

  localparam logic [PAGE_W-1:0]  STATIC_PAGE   = 2'h1;
  localparam logic [PAGE_W-1:0]  PAGE_RESET    = 2'h0;
  localparam logic [DATA_W-1:0]  PAGE_SEL_ADDR = 8'hca;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL    = 3'h6;

  // Vector areas inside the static page
  localparam logic [PC_W-1:0] IRQ_VEC_LO   = 12'hff0;
  localparam logic [PC_W-1:0] IRQ_VEC_HI   = 12'hff7;
  localparam logic [PC_W-1:0] NMI_VEC_LO   = 12'hffc;
  localparam logic [PC_W-1:0] NMI_VEC_HI   = 12'hffd;
  localparam logic [PC_W-1:0] RESET_VEC_LO = 12'hffe;

  typedef enum logic [1:0] {FETCH_CODE, FETCH_IRQ_VEC, FETCH_NMI_VEC, FETCH_RESET_VEC} fetch_class_e;

  // Controller register indices on its software port
  localparam logic [3:0] HREG_FETCH  = 4'h0;
  localparam logic [3:0] HREG_DWRITE = 4'h1;
  localparam logic [3:0] HREG_DBIT   = 4'h2;
  localparam logic [3:0] HREG_CALL   = 4'h3;
  localparam logic [3:0] HREG_RET    = 4'h4;
  localparam logic [3:0] HREG_CTRL   = 4'h5;
  localparam logic [3:0] HREG_STATUS = 4'h6;

  localparam int CTRL_ISR_BIT   = 0;
  localparam int CTRL_ALLOW_BIT = 1;
  localparam int STAT_REFUSED   = 0;
  localparam int STAT_EMPTY     = 1;
  localparam int STAT_IMAGE_LSB = 2;
  localparam int STAT_STATIC    = 4;
  localparam int STAT_SEEN      = 5;

  function automatic logic [MEM_AW-1:0] phys_addr(input logic [PC_W-1:0]   pc,
                                                  input logic [PAGE_W-1:0] page);
    logic [PAGE_W-1:0] eff;
    eff = pc[PC_W-1] ? STATIC_PAGE : page;
    return {eff, pc[PC_W-2:0]};
  endfunction

  function automatic fetch_class_e classify(input logic [PC_W-1:0] pc);
    fetch_class_e c;
    c = FETCH_CODE;
    if (pc >= RESET_VEC_LO)
      c = FETCH_RESET_VEC;
    else if (pc >= NMI_VEC_LO && pc <= NMI_VEC_HI)
      c = FETCH_NMI_VEC;
    else if (pc >= IRQ_VEC_LO && pc <= IRQ_VEC_HI)
      c = FETCH_IRQ_VEC;
    return c;
  endfunction

endpackage

// file: verif/program_page_mapper_asserts.sv
module program_page_mapper_checker
  import program_page_pkg::*;
(
  input wire logic                                clk_sys_in,      // Clock
  input wire logic                                rst_in,          // Sync reset
  input wire logic                                fetch_req,       // Fetch strobe
  input wire logic [program_page_pkg::PC_W-1:0]   fetch_pc,        // Fetch counter
  input wire logic                                fetch_valid,     // Fetch answer
  input wire logic [program_page_pkg::DATA_W-1:0] fetch_data,      // Fetched byte
  input program_page_pkg::fetch_class_e           fetch_class,     // Vector class
  input wire logic                                data_wr,         // Data write
  input wire logic                                data_bit_op,     // Bit operation
  input wire logic [program_page_pkg::DATA_W-1:0] data_addr,       // Data address
  input wire logic [program_page_pkg::DATA_W-1:0] data_wdata,      // Data byte
  input wire logic                                call_push,       // Push
  input wire logic [program_page_pkg::PC_W-1:0]   call_addr,       // Pushed address
  input wire logic                                ret_pop,         // Pop
  input wire logic [program_page_pkg::PC_W-1:0]   ret_addr,        // Popped address
  input wire logic                                stack_empty,     // Empty level
  input wire logic [program_page_pkg::MEM_AW-1:0] mem_addr_out,    // Memory address
  input wire logic                                mem_rd_out,      // Memory read
  input wire logic [program_page_pkg::DATA_W-1:0] mem_data_in,     // Memory data
  input wire logic [program_page_pkg::PAGE_W-1:0] page_out,        // Page select
  input wire logic [program_page_pkg::DEPTH_W-1:0] stack_depth_out // Stack level
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  function automatic logic [1:0] vec_kind(input logic [11:0] a);
    if (a >= 12'hffe)
      return 2'h3;
    if (a >= 12'hffc)
      return 2'h2;
    if (a >= 12'hff0 && a <= 12'hff7)
      return 2'h1;
    return 2'h0;
  endfunction

  a_upper_static:
    assert property (fetch_req && fetch_pc[11] |=> mem_rd_out && mem_addr_out == {2'h1, $past(fetch_pc[10:0])})
    else $error("upper fetch did not reach the static page");
  a_lower_selected:
    assert property (fetch_req && !fetch_pc[11] |=> mem_rd_out && mem_addr_out == {$past(page_out), $past(fetch_pc[10:0])})
    else $error("lower fetch did not reach the selected page");
  a_fetch_class:
    assert property (fetch_req |-> ##2 fetch_valid && fetch_class == vec_kind($past(fetch_pc, 2)))
    else $error("fetch class wrong");
  a_fetch_data:
    assert property (mem_rd_out |=> fetch_valid && fetch_data == $past(mem_data_in))
    else $error("fetched byte not returned");
  a_page_write:
    assert property (data_wr && data_addr == 8'hca && !data_bit_op |=> page_out == $past(data_wdata[1:0]))
    else $error("page select write not taken");
  a_page_hold:
    assert property (!(data_wr && data_addr == 8'hca && !data_bit_op) |=> $stable(page_out))
    else $error("page select changed without a write");
  a_push_depth:
    assert property (call_push && !ret_pop && stack_depth_out < 3'h6 |=> stack_depth_out == $past(stack_depth_out) + 3'h1)
    else $error("push did not grow the stack");
  a_pop_depth:
    assert property (ret_pop && !call_push && stack_depth_out != 3'h0 |=> stack_depth_out == $past(stack_depth_out) - 3'h1)
    else $error("pop did not shrink the stack");
  a_return_order:
    assert property (call_push ##1 (ret_pop && !call_push) |=> ret_addr == $past(call_addr, 2))
    else $error("pop did not return the last push");
  a_empty_flag:
    assert property (stack_empty == (stack_depth_out == 3'h0))
    else $error("empty flag disagrees with depth");
  a_empty_pop:
    assert property (ret_pop && !call_push && stack_empty |=> ret_addr == 12'h000 && stack_empty)
    else $error("pop from an empty stack did not return zero");
endmodule

// file: verif/program_page_mapper_tb_top.sv
module program_page_mapper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import program_page_pkg::*;

  logic              clk_sys_in = 1'b0;
  logic              rst_in = 1'b1;
  logic [3:0]        sw_addr = 4'h0;
  logic [15:0]       sw_wdata = 16'h0;
  logic              sw_wr = 1'b0;
  logic              sw_rd = 1'b0;
  logic [15:0]       sw_rdata;
  logic [MEM_AW-1:0] mem_addr;
  logic              mem_rd;
  logic [DATA_W-1:0] mem_data;
  logic [PAGE_W-1:0] page;
  logic              page_written;
  logic [2:0]        depth;
  logic              ovf;
  logic              unf;
  int                err_total = 0;
  int                checked = 0;
  logic [15:0]       d;

  // Each byte carries its page number so a wrong page shows in the data
  assign mem_data = {mem_addr[12:11], mem_addr[5:0]};

  program_page_if bus_if ();
  program_page_core i_program_page_core (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .map_if(bus_if),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata));
  program_page_mapper i_program_page_mapper (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .core_if(bus_if),
    .mem_addr_out(mem_addr), .mem_rd_out(mem_rd), .mem_data_in(mem_data), .page_out(page),
    .page_written_out(page_written), .stack_depth_out(depth), .stack_overflow_out(ovf),
    .stack_underflow_out(unf));
  program_page_mapper_checker i_checker (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .fetch_req(bus_if.fetch_req), .fetch_pc(bus_if.fetch_pc), .fetch_valid(bus_if.fetch_valid),
    .fetch_data(bus_if.fetch_data), .fetch_class(bus_if.fetch_class), .data_wr(bus_if.data_wr),
    .data_bit_op(bus_if.data_bit_op), .data_addr(bus_if.data_addr), .data_wdata(bus_if.data_wdata),
    .call_push(bus_if.call_push), .call_addr(bus_if.call_addr), .ret_pop(bus_if.ret_pop),
    .ret_addr(bus_if.ret_addr), .stack_empty(bus_if.stack_empty), .mem_addr_out(mem_addr),
    .mem_rd_out(mem_rd), .mem_data_in(mem_data), .page_out(page), .stack_depth_out(depth));

  initial
  begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sw_write(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk_sys_in);
    sw_wr <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic sw_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys_in);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask

  // Fetch one byte and compare class, page and offset seen by software
  task automatic fetch_chk(input logic [11:0] pc, input logic [1:0] pg, input logic [1:0] cls);
    logic [15:0] v;
    sw_write(HREG_FETCH, {4'h0, pc});
    sw_read(HREG_FETCH, v);
    chk(v, {6'h0, cls, (pc[11] ? 2'h1 : pg), pc[5:0]});
  endtask

  task automatic t_reset_state();
    sw_read(HREG_STATUS, d);
    chk(d, 16'h0012);
    chk({15'h0, page_written}, 16'h0);
    sw_read(4'hf, d);
    chk(d, 16'h0);
  endtask

  task automatic t_pages();
    for (int p = 0; p < 4; p++)
    begin
      fetch_chk(12'h823, 2'h0, 2'h0);
      sw_write(HREG_DWRITE, {8'hca, 6'h3f, p[1:0]});
      chk({14'h0, page}, p[15:0]);
      fetch_chk(12'h023, p[1:0], 2'h0);
      fetch_chk(12'h823, p[1:0], 2'h0);
    end
    chk({15'h0, page_written}, 16'h1);
  endtask

  task automatic t_refused();
    fetch_chk(12'h7ff, 2'h3, 2'h0);
    sw_write(HREG_DWRITE, {8'hca, 8'h00});
    chk({14'h0, page}, 16'h3);
    sw_read(HREG_STATUS, d);
    chk({15'h0, d[0]}, 16'h1);
    fetch_chk(12'h800, 2'h3, 2'h0);
    sw_write(HREG_DBIT, {8'hca, 8'h00});
    sw_write(HREG_DWRITE, {8'hcb, 8'h00});
    chk({14'h0, page}, 16'h3);
    sw_write(HREG_STATUS, 16'h1);
    sw_read(HREG_STATUS, d);
    chk({15'h0, d[0]}, 16'h0);
    sw_write(HREG_CTRL, 16'h1);
    sw_write(HREG_DWRITE, {8'hca, 8'h00});
    sw_read(HREG_STATUS, d);
    chk({15'h0, d[0]}, 16'h1);
    chk({14'h0, page}, 16'h3);
    sw_write(HREG_CTRL, 16'h3);
    sw_read(HREG_CTRL, d);
    chk(d, 16'h3);
    sw_write(HREG_DWRITE, {8'hca, 8'h02});
    sw_read(HREG_STATUS, d);
    chk({14'h0, d[3:2]}, 16'h2);
    chk({14'h0, page}, 16'h2);
    sw_write(HREG_CTRL, 16'h0);
  endtask

  task automatic t_vectors();
    logic [11:0] pcs [7] = '{12'hff0, 12'hff7, 12'hff8, 12'hffc, 12'hffd, 12'hffe, 12'hfff};
    logic [1:0]  cls [7] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 7; i++)
      fetch_chk(pcs[i], 2'h2, cls[i]);
  endtask

  // Call and return strobes in adjacent cycles, as a leaf routine does
  task automatic t_call_ret();
    @(posedge clk_sys_in);
    sw_addr <= HREG_CALL;
    sw_wdata <= 16'h0abc;
    sw_wr <= 1'b1;
    @(posedge clk_sys_in);
    sw_addr <= HREG_RET;
    @(posedge clk_sys_in);
    sw_wr <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    sw_read(HREG_RET, d);
    chk(d, 16'h0abc);
    chk({13'h0, depth}, 16'h0);
    chk({14'h0, page}, 16'h2);
  endtask

  // Seven pushes overrun six levels, so the oldest entry is lost
  task automatic t_stack();
    for (int i = 1; i <= 7; i++)
      sw_write(HREG_CALL, 16'h0100 + 16'(i));
    chk({13'h0, depth}, 16'h6);
    chk({15'h0, ovf}, 16'h1);
    chk({14'h0, page}, 16'h2);
    for (int i = 7; i >= 2; i--)
    begin
      sw_write(HREG_RET, 16'h0);
      sw_read(HREG_RET, d);
      chk(d, 16'h0100 + 16'(i));
    end
    sw_read(HREG_STATUS, d);
    chk({15'h0, d[1]}, 16'h1);
    chk({15'h0, unf}, 16'h0);
    sw_write(HREG_RET, 16'h0);
    sw_read(HREG_RET, d);
    chk(d, 16'h0);
    chk({15'h0, unf}, 16'h1);
    chk({14'h0, page}, 16'h2);
  endtask

  task automatic end_sim();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset_state();
    t_pages();
    t_refused();
    t_vectors();
    t_call_ret();
    t_stack();
    end_sim();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    err_total++;
    end_sim();
  end
endmodule
